// File: verilog/usart_defs.svh
`ifndef USART_DEFS_SVH
`define USART_DEFS_SVH

// Register addresses
`define ADDR_DATA 3'h0
`define ADDR_CSA 3'h1
`define ADDR_CSB 3'h2
`define ADDR_CSC 3'h3
`define ADDR_BAUD_LO 3'h4
`define ADDR_BAUD_HI 3'h5

// Status A fields
`define CSA_RXC 7
`define CSA_TXC 6
`define CSA_DRE 5
`define CSA_FERR 4
`define CSA_OVR 3
`define CSA_PE 2
`define CSA_DBL 1

// Control B fields
`define CSB_RXIE 7
`define CSB_TXIE 6
`define CSB_DREIE 5
`define CSB_RXEN 4
`define CSB_TXEN 3
`define CSB_SIZE2 2
`define CSB_RX9 1
`define CSB_TX9 0

// Control C fields
`define CSC_SYNC 6
`define CSC_PAR_EN 5
`define CSC_PAR_ODD 4
`define CSC_STOP2 3
`define CSC_POL 0

// Reset values
`define CSB_RESET 8'h00
`define CSC_RESET 7'h06

// Character size code for nine bits
`define SIZE_9 3'h7

// Last oversample count per bit
`define OVS_NORMAL_LAST 4'hf
`define OVS_DOUBLE_LAST 4'h7

// Receive entry layout
`define ENT_D9 8
`define ENT_FERR 9
`define ENT_OVR 10
`define ENT_PE 11
`define ENT_W 12

`endif

// File: verilog/usart_pkg.sv
package usart_pkg;

  typedef enum logic {tx_idle, tx_busy} tx_state_type;

  typedef enum logic [1:0] {rx_idle, rx_start, rx_bits} rx_state_type;

endpackage

// File: verilog/sync3.sv
`timescale 1ns/100ps
`default_nettype none

module sync3 #(
  parameter logic RESET_LEVEL = 1'b1
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Level
  input wire logic din,
  output logic dout
);

  logic s1;
  logic s2;
  logic s3;

  // A change counts once the second and third stages agree
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1 <= RESET_LEVEL;
      s2 <= RESET_LEVEL;
      s3 <= RESET_LEVEL;
      dout <= RESET_LEVEL;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        dout <= s3;
      end
    end
  end

endmodule // sync3

`default_nettype wire

// File: verilog/baud_gen.sv
`timescale 1ns/100ps
`default_nettype none

module baud_gen #(
  parameter int WIDTH = 12
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Divisor
  input wire logic [WIDTH-1:0] divisor,
  input wire logic reload,
  // Output pulse
  output logic tick
);

  logic [WIDTH-1:0] count;

  assign tick = (count == {WIDTH{1'b0}});

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= {WIDTH{1'b0}};
    end else if (reload || tick) begin
      count <= divisor;
    end else begin
      count <= count - 1'b1;
    end
  end

endmodule // baud_gen

`default_nettype wire

// File: verilog/usart_clock_gen_rx_buffer.sv
// What this block does
// - Four clock modes: normal, double, master, slave
// - Mode bit picks sync; pin direction picks master
// - Double speed acts only when asynchronous
// - Transfer clock pin used only in sync mode
// - Baud counter reloads at zero or low write
// - One baud pulse per zero, rate clk/(div+1)
// - Transmit bit clock is baud over 2/8/16
// - Receiver recovery runs on baud pulses directly
// - One transmit buffer allows back-to-back frames
// - Two-entry receive FIFO, each read pops once
// - Error flags and ninth bit stored per character
// - Shift register holds third character until start
// - Detect frame, overrun and parity errors
// - Five to nine data bits, 1-2 stops, parity
// - Three requests: rx done, tx done, empty
// - Majority filter and false start rejection
// - Compat mode: second unit off, async only
// - Master drives pin clock; slave takes it
// - Double speed uses eight samples per bit
// - Pin clock synchronised and edge detected
// - Polarity picks change edge and sample edge
// - Low start, LSB first, parity, high stops
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "usart_defs.svh"

module usart_clock_gen_rx_buffer #(
  parameter int UNIT_INDEX = 0,
  parameter int DIV_WIDTH = 12
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Straps and pin direction
  input wire logic compat_mode,
  input wire logic xfer_clock_pin_direction,
  // Serial data pins
  input wire logic rxd,
  output logic txd,
  // Transfer clock pin
  input wire logic transfer_clock_pin_in,
  output logic transfer_clock_pin_out,
  output logic transfer_clock_pin_oe,
  // Interrupt requests
  output logic rx_complete_irq,
  output logic tx_complete_irq,
  output logic data_empty_irq
);

  // Register storage
  logic double_speed_bit;
  logic [7:0] ctrl_b;
  logic [6:0] ctrl_c;
  logic [7:0] baud_divisor_low;
  logic [DIV_WIDTH-9:0] baud_divisor_high;

  // Transmit state
  usart_pkg::tx_state_type tx_state;
  logic [8:0] tx_buf;
  logic tx_buf_full;
  logic tx_complete;
  logic [12:0] tx_shift;
  logic [3:0] tx_left;
  logic [3:0] tx_div;

  // Receive state
  usart_pkg::rx_state_type rx_state;
  logic [3:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [8:0] rx_shift;
  logic rx_par_bit;
  logic [2:0] rx_win;
  logic hold_valid;
  logic [`ENT_W-1:0] hold_entry;
  logic ovr_pending;
  logic [`ENT_W-1:0] rx_fifo [2];
  logic rx_wp;
  logic rx_rp;
  logic [1:0] rx_count;

  // Clock pin state
  logic lclk_int;
  logic lclk_prev;
  logic lclk_sync;
  logic rx_in;
  logic baud_tick;

  // Register decode
  wire logic wr_data = wr && (addr == `ADDR_DATA);
  wire logic wr_csa = wr && (addr == `ADDR_CSA);
  wire logic wr_csb = wr && (addr == `ADDR_CSB);
  wire logic wr_csc = wr && (addr == `ADDR_CSC) && !compat_mode;
  wire logic wr_lo = wr && (addr == `ADDR_BAUD_LO);
  wire logic wr_hi = wr && (addr == `ADDR_BAUD_HI) && !compat_mode;
  wire logic rd_data = rd && (addr == `ADDR_DATA);

  // Effective modes
  wire logic unit_off = compat_mode && (UNIT_INDEX != 0);
  wire logic sync_mode = ctrl_c[`CSC_SYNC] && !compat_mode;
  wire logic master = sync_mode && xfer_clock_pin_direction;
  wire logic double = double_speed_bit && !sync_mode;
  wire logic [3:0] ovs_last = double ? `OVS_DOUBLE_LAST : `OVS_NORMAL_LAST;
  wire logic [3:0] ovs_mid = {1'b0, ovs_last[3:1]};
  wire logic tx_en = ctrl_b[`CSB_TXEN] && !unit_off;
  wire logic rx_en = ctrl_b[`CSB_RXEN] && !unit_off;

  // Frame format
  wire logic [2:0] char_size = {ctrl_b[`CSB_SIZE2], ctrl_c[2:1]};
  wire logic [3:0] nbits = (char_size == `SIZE_9) ? 4'h9 : 4'h5 + {2'h0, char_size[1:0]};
  wire logic par_en = ctrl_c[`CSC_PAR_EN];
  wire logic par_odd = ctrl_c[`CSC_PAR_ODD];
  wire logic [8:0] data_mask = 9'h1ff >> (4'h9 - nbits);

  // Baud generator
  wire logic [DIV_WIDTH-1:0] baud_now = {baud_divisor_high, baud_divisor_low};
  wire logic [DIV_WIDTH-1:0] baud_next = wr_lo ? {baud_divisor_high, wdata} : baud_now;

  baud_gen #(
    .WIDTH(DIV_WIDTH)
  ) u_baud (
    .clk(clk),
    .nrst(nrst),
    .divisor(baud_next),
    .reload(wr_lo),
    .tick(baud_tick)
  );

  // Pin inputs
  sync3 #(
    .RESET_LEVEL(1'b1)
  ) u_rx_sync (
    .clk(clk),
    .nrst(nrst),
    .din(rxd),
    .dout(rx_in)
  );

  sync3 #(
    .RESET_LEVEL(1'b0)
  ) u_lclk_sync (
    .clk(clk),
    .nrst(nrst),
    .din(transfer_clock_pin_in),
    .dout(lclk_sync)
  );

  // Link clock: master divides baud by two, slave follows the pin
  wire logic clk_level = master ? lclk_int : lclk_sync;
  wire logic lclk_rise = sync_mode && clk_level && !lclk_prev;
  wire logic lclk_fall = sync_mode && !clk_level && lclk_prev;
  wire logic pol = ctrl_c[`CSC_POL];
  wire logic change_edge = pol ? lclk_fall : lclk_rise;
  wire logic sample_edge = pol ? lclk_rise : lclk_fall;

  assign transfer_clock_pin_out = lclk_int;
  assign transfer_clock_pin_oe = master && !unit_off;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lclk_int <= 1'b0;
      lclk_prev <= 1'b0;
    end else begin
      lclk_prev <= clk_level;
      if (!master) begin
        lclk_int <= 1'b0;
      end else if (baud_tick) begin
        lclk_int <= ~lclk_int;
      end
    end
  end

  // Transmit frame assembly
  function automatic logic [12:0] build_frame(input logic [8:0] d, input logic [3:0] n,
                                              input logic pe, input logic p);
    logic [12:0] f;
    f = 13'h1fff;
    f[0] = 1'b0;
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < n) begin
        f[i + 1] = d[i];
      end
    end
    if (pe) begin
      f[n + 4'h1] = p;
    end
    return f;
  endfunction

  wire logic tx_par = (^(tx_buf & data_mask)) ^ par_odd;
  wire logic [12:0] tx_frame = build_frame(tx_buf, nbits, par_en, tx_par);
  wire logic [3:0] tx_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, ctrl_c[`CSC_STOP2]};
  wire logic tx_tick = sync_mode ? change_edge : (baud_tick && (tx_div == ovs_last));
  wire logic tx_busy = (tx_state == usart_pkg::tx_busy);
  wire logic frame_done = tx_busy && tx_tick && (tx_left == 4'h0);
  wire logic tx_go = !sync_mode || change_edge;
  wire logic tx_load = tx_en && tx_buf_full && ((!tx_busy && tx_go) || frame_done);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= usart_pkg::tx_idle;
      tx_shift <= 13'h1fff;
      tx_left <= 4'h0;
      tx_div <= 4'h0;
      txd <= 1'b1;
    end else if (!tx_en) begin
      tx_state <= usart_pkg::tx_idle;
      txd <= 1'b1;
    end else if (tx_load) begin
      tx_state <= usart_pkg::tx_busy;
      txd <= tx_frame[0];
      tx_shift <= {1'b1, tx_frame[12:1]};
      tx_left <= tx_len - 4'h1;
      tx_div <= 4'h0;
    end else begin
      if (baud_tick) begin
        tx_div <= (tx_div == ovs_last) ? 4'h0 : tx_div + 4'h1;
      end
      if (frame_done) begin
        tx_state <= usart_pkg::tx_idle;
      end else if (tx_busy && tx_tick) begin
        txd <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[12:1]};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

  // Transmit buffer and completion flag; set wins over clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_buf <= 9'h000;
      tx_buf_full <= 1'b0;
      tx_complete <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_buf <= {ctrl_b[`CSB_TX9], wdata};
        tx_buf_full <= 1'b1;
      end else if (tx_load) begin
        tx_buf_full <= 1'b0;
      end
      if (frame_done && !tx_load) begin
        tx_complete <= 1'b1;
      end else if (wr_csa && wdata[`CSA_TXC]) begin
        tx_complete <= 1'b0;
      end
    end
  end

  // Receive sampling
  wire logic vote = (rx_win[0] & rx_win[1]) | (rx_win[0] & rx_win[2]) | (rx_win[1] & rx_win[2]);
  wire logic rx_bit = sync_mode ? rx_in : vote;
  wire logic rx_strobe = sync_mode ? sample_edge : (baud_tick && (rx_cnt == ovs_mid));
  wire logic rx_idle = (rx_state == usart_pkg::rx_idle);
  wire logic start_seen = rx_en && rx_idle && (sync_mode ? (sample_edge && !rx_in) : (baud_tick && !vote));
  wire logic rx_pop = rd_data && (rx_count != 2'h0);
  wire logic rx_room = (rx_count != 2'h2) || rx_pop;
  wire logic rx_push = hold_valid && rx_room;
  wire logic rx_overrun = start_seen && hold_valid && !rx_room;
  wire logic [8:0] rx_data = rx_shift >> (4'h9 - nbits);
  wire logic rx_perr = par_en && (rx_par_bit != ((^rx_data) ^ par_odd));
  wire logic [`ENT_W-1:0] new_entry = {rx_perr, ovr_pending, !rx_bit, rx_data};
  wire logic rx_last = rx_idx == (nbits + {3'h0, par_en});

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= usart_pkg::rx_idle;
      rx_cnt <= 4'h0;
      rx_idx <= 4'h0;
      rx_shift <= 9'h000;
      rx_par_bit <= 1'b0;
      rx_win <= 3'h7;
      hold_valid <= 1'b0;
      hold_entry <= {`ENT_W{1'b0}};
      ovr_pending <= 1'b0;
    end else begin
      if (baud_tick) begin
        rx_win <= {rx_win[1:0], rx_in};
      end
      if (start_seen) begin
        rx_cnt <= 4'h0;
      end else if (baud_tick) begin
        rx_cnt <= (rx_cnt == ovs_last) ? 4'h0 : rx_cnt + 4'h1;
      end
      if (rx_push) begin
        hold_valid <= 1'b0;
      end
      if (rx_overrun) begin
        ovr_pending <= 1'b1;
        hold_valid <= 1'b0;
      end
      case (rx_state)
        usart_pkg::rx_idle: begin
          if (start_seen) begin
            rx_state <= sync_mode ? usart_pkg::rx_bits : usart_pkg::rx_start;
            rx_idx <= 4'h0;
          end
        end
        usart_pkg::rx_start: begin
          if (!rx_en) begin
            rx_state <= usart_pkg::rx_idle;
          end else if (rx_strobe) begin
            rx_state <= rx_bit ? usart_pkg::rx_idle : usart_pkg::rx_bits;
          end
        end
        usart_pkg::rx_bits: begin
          if (!rx_en) begin
            rx_state <= usart_pkg::rx_idle;
          end else if (rx_strobe) begin
            rx_idx <= rx_idx + 4'h1;
            if (rx_idx < nbits) begin
              rx_shift <= {rx_bit, rx_shift[8:1]};
            end else if (!rx_last) begin
              rx_par_bit <= rx_bit;
            end else begin
              hold_entry <= new_entry;
              hold_valid <= 1'b1;
              ovr_pending <= 1'b0;
              rx_state <= usart_pkg::rx_idle;
            end
          end
        end
        default: begin
          rx_state <= usart_pkg::rx_idle;
        end
      endcase
    end
  end

  // Two-entry receive FIFO
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_fifo[rx_wp] <= hold_entry;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_wp <= 1'b0;
      rx_rp <= 1'b0;
      rx_count <= 2'h0;
    end else begin
      if (rx_push) begin
        rx_wp <= ~rx_wp;
      end
      if (rx_pop) begin
        rx_rp <= ~rx_rp;
      end
      rx_count <= rx_count + {1'b0, rx_push} - {1'b0, rx_pop};
    end
  end

  wire logic rx_avail = (rx_count != 2'h0);
  wire logic [`ENT_W-1:0] rx_head = rx_avail ? rx_fifo[rx_rp] : {`ENT_W{1'b0}};

  // Register writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      double_speed_bit <= 1'b0;
      ctrl_b <= `CSB_RESET;
      ctrl_c <= `CSC_RESET;
      baud_divisor_low <= 8'h00;
      baud_divisor_high <= '0;
    end else begin
      if (wr_csa) begin
        double_speed_bit <= wdata[`CSA_DBL];
      end
      if (wr_csb) begin
        ctrl_b <= {wdata[7:2], 1'b0, wdata[0]};
      end
      if (wr_csc) begin
        ctrl_c <= wdata[6:0];
      end
      if (wr_lo) begin
        baud_divisor_low <= wdata;
      end
      if (wr_hi) begin
        baud_divisor_high <= wdata[DIV_WIDTH-9:0];
      end
    end
  end

  // Register reads
  wire logic [7:0] csa_value = {rx_avail, tx_complete, !tx_buf_full, rx_head[`ENT_FERR],
                                rx_head[`ENT_OVR], rx_head[`ENT_PE], double_speed_bit, 1'b0};
  wire logic [7:0] csb_value = {ctrl_b[7:2], rx_head[`ENT_D9], ctrl_b[0]};
  wire logic [7:0] csc_value = compat_mode ? 8'h00 : {1'b0, ctrl_c};
  wire logic [7:0] hi_value = compat_mode ? 8'h00 : 8'(baud_divisor_high);
  logic [7:0] next_rdata;

  always_comb begin
    case (addr)
      `ADDR_DATA: next_rdata = rx_head[7:0];
      `ADDR_CSA: next_rdata = csa_value;
      `ADDR_CSB: next_rdata = csb_value;
      `ADDR_CSC: next_rdata = csc_value;
      `ADDR_BAUD_LO: next_rdata = baud_divisor_low;
      `ADDR_BAUD_HI: next_rdata = hi_value;
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data and requests
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata <= 8'h00;
      rx_complete_irq <= 1'b0;
      tx_complete_irq <= 1'b0;
      data_empty_irq <= 1'b0;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
      rx_complete_irq <= ctrl_b[`CSB_RXIE] && rx_avail;
      tx_complete_irq <= ctrl_b[`CSB_TXIE] && tx_complete;
      data_empty_irq <= ctrl_b[`CSB_DREIE] && !tx_buf_full;
    end
  end

endmodule // usart_clock_gen_rx_buffer

`default_nettype wire

// File: dv/usart_clock_gen_rx_buffer_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "usart_defs.svh"

module usart_clock_gen_rx_buffer_checker #(
  parameter int DIV_WIDTH = 12
) (
  // System
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  // Straps and pins
  input wire logic compat_mode,
  input wire logic xfer_clock_pin_direction,
  input wire logic txd,
  input wire logic transfer_clock_pin_out,
  input wire logic transfer_clock_pin_oe,
  // Requests
  input wire logic rx_complete_irq,
  input wire logic data_empty_irq
);
  default clocking dflt @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [DIV_WIDTH-1:0] div;
  logic [DIV_WIDTH-1:0] gap;
  logic [7:0] ctl_b;
  logic sync;
  logic fresh;
  logic last_out;
  wire logic div_lo_wr = wr && addr == `ADDR_BAUD_LO;
  wire logic div_hi_wr = wr && addr == `ADDR_BAUD_HI && !compat_mode;
  wire logic out_moved = transfer_clock_pin_out != last_out;

  // Shadow of the control bits that gate the outputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctl_b <= `CSB_RESET;
      sync <= 1'b0;
    end else if (wr && addr == `ADDR_CSB) begin
      ctl_b <= wdata;
    end else if (wr && addr == `ADDR_CSC && !compat_mode) begin
      sync <= wdata[`CSC_SYNC];
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div <= '0;
    end else if (div_lo_wr) begin
      div[7:0] <= wdata;
    end else if (div_hi_wr) begin
      div[DIV_WIDTH-1:8] <= wdata[DIV_WIDTH-9:0];
    end
  end
  // Spacing of pin clock moves; clean only after a move with no divisor write
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gap <= '0;
      fresh <= 1'b0;
      last_out <= 1'b0;
    end else begin
      gap <= out_moved ? '0 : gap + 1'b1;
      fresh <= transfer_clock_pin_oe && !div_lo_wr && !div_hi_wr && (fresh || out_moved);
      last_out <= transfer_clock_pin_out;
    end
  end

  a_rdata_one_cycle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  a_compat_regs_gone: assert property (compat_mode && rd &&
    (addr == `ADDR_CSC || addr == `ADDR_BAUD_HI) |=> rdata == 8'h00)
    else $error("hidden register readable in legacy mode");
  a_pin_needs_sync: assert property (transfer_clock_pin_oe |-> sync && xfer_clock_pin_direction)
    else $error("clock pin driven outside sync master");
  a_compat_no_pin: assert property (compat_mode && $past(compat_mode) |-> !transfer_clock_pin_oe)
    else $error("clock pin driven in legacy mode");
  a_slave_pin_quiet: assert property (!transfer_clock_pin_oe [*2] |-> !transfer_clock_pin_out)
    else $error("clock pin output moves while not master");
  a_master_period: assert property (fresh && transfer_clock_pin_oe && out_moved |-> gap == div)
    else $error("pin clock spacing differs from divisor plus one");
  a_empty_irq_gated: assert property (data_empty_irq |-> $past(ctl_b[`CSB_DREIE]))
    else $error("empty request without its enable");
  a_rx_irq_off: assert property ($fell(ctl_b[`CSB_RXIE]) |=> !rx_complete_irq)
    else $error("receive request stays after disable");
  a_txd_off_idle: assert property (!ctl_b[`CSB_TXEN] [*2] |-> txd)
    else $error("line not idle high with transmitter off");

  c_master_clock: cover property (transfer_clock_pin_oe && out_moved);
  c_data_read: cover property (rd && addr == `ADDR_DATA ##1 rdata != 8'h00);
  c_rx_request: cover property (rx_complete_irq);
endmodule // usart_clock_gen_rx_buffer_checker

bind usart_clock_gen_rx_buffer usart_clock_gen_rx_buffer_checker #(.DIV_WIDTH(DIV_WIDTH)) chk_i (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .compat_mode(compat_mode), .xfer_clock_pin_direction(xfer_clock_pin_direction), .txd(txd),
  .transfer_clock_pin_out(transfer_clock_pin_out), .transfer_clock_pin_oe(transfer_clock_pin_oe),
  .rx_complete_irq(rx_complete_irq), .data_empty_irq(data_empty_irq));
`default_nettype wire

// File: dv/remote_uart.sv
`timescale 1ns/100ps
`default_nettype none

module remote_uart (
  // System
  input wire logic clk,
  input wire logic [4:0] bit_cycles,
  // Serial lines
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got_q[$];
  time start_q[$];
  logic [7:0] shift;
  initial rxd = 1'b1;

  // Frame bits come from the caller, start first
  task automatic send(input logic [11:0] bits, input int len);
    for (int i = 0; i < len; i++) begin
      rxd <= bits[i];
      repeat (bit_cycles) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask

  // Mid-bit sampling of frames from the block
  always begin
    @(negedge txd);
    start_q.push_back($time);
    repeat (bit_cycles / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (bit_cycles) @(posedge clk);
      shift[i] = txd;
    end
    repeat (bit_cycles) @(posedge clk);
    if (txd === 1'b1) got_q.push_back(shift);
  end
endmodule // remote_uart
`default_nettype wire

// File: dv/test_usart_clock_gen_rx_buffer.sv
`timescale 1ns/100ps
`default_nettype none
`include "usart_defs.svh"

module test_usart_clock_gen_rx_buffer;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic compat_mode = 1'b0;
  logic dir = 1'b0;
  logic [4:0] bit_cycles = 5'h10;
  logic [7:0] rdata;
  logic rxd, txd, pin_out, pin_oe, rx_irq, tc_irq, de_irq, last;
  logic lclk_in = 1'b0;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  logic [7:0] v;
  logic [7:0] q[4];
  logic [2:0] rst_a[4] = '{3'h1, 3'h2, 3'h3, 3'h6};
  logic [7:0] rst_v[4] = '{8'h20, 8'h00, 8'h06, 8'h00};

  always #50 clk = ~clk;

  usart_clock_gen_rx_buffer #(.UNIT_INDEX(0), .DIV_WIDTH(12)) usart_clock_gen_rx_buffer_i (
    .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .compat_mode(compat_mode), .xfer_clock_pin_direction(dir), .rxd(rxd), .txd(txd),
    .transfer_clock_pin_in(lclk_in), .transfer_clock_pin_out(pin_out),
    .transfer_clock_pin_oe(pin_oe), .rx_complete_irq(rx_irq), .tx_complete_irq(tc_irq),
    .data_empty_irq(de_irq));
  remote_uart remote_uart_i (.clk(clk), .bit_cycles(bit_cycles), .txd(txd), .rxd(rxd));

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Status first, then the data read that pops the entry
  task automatic chk_rx(input logic [7:0] d, input logic [2:0] fl);
    logic [7:0] s;
    rd_reg(`ADDR_CSA, s);
    chk(s & 8'h9c, {1'b1, 2'b00, fl, 2'b00});
    rd_reg(`ADDR_DATA, s);
    chk(s, d);
  endtask

  task automatic rx_send(input logic [7:0] d, input logic par, input logic pe, input logic se);
    @(posedge clk);
    remote_uart_i.send(frame(d, par, pe, se), par ? 11 : 10);
    repeat (20) @(posedge clk);
  endtask

  task automatic wait_tx(input int cnt);
    for (int i = 0; i < 4000 && remote_uart_i.got_q.size() < cnt; i++) @(posedge clk);
  endtask

  // Start, data LSB first, optional even parity, stop
  function automatic logic [11:0] frame(input logic [7:0] d, input logic par, input logic pe,
                                        input logic se);
    frame = par ? {1'b1, !se, (^d) ^ pe, d, 1'b0} : {2'b11, !se, d, 1'b0};
  endfunction

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      miscompares++;
      give_verdict;
    end
  end

  initial begin
    void'($urandom(28919));
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    wr_reg(3'h6, 8'hff);
    foreach (rst_a[i]) begin
      rd_reg(rst_a[i], v);
      chk(v, rst_v[i]);
    end
    // Two frames back to back through the single write buffer
    wr_reg(`ADDR_CSB, 8'h18);
    q[0] = $urandom;
    q[1] = $urandom;
    wr_reg(`ADDR_DATA, q[0]);
    repeat (3) @(posedge clk);
    wr_reg(`ADDR_DATA, q[1]);
    wait_tx(2);
    chk(remote_uart_i.got_q[0], q[0]);
    chk(remote_uart_i.got_q[1], q[1]);
    chk(8'((remote_uart_i.start_q[1] - remote_uart_i.start_q[0]) / 100), 8'ha0);
    // Four frames unread: third level dropped by the fourth start
    for (int i = 0; i < 4; i++) begin
      q[i] = $urandom;
      rx_send(q[i], 1'b0, 1'b0, 1'b0);
    end
    chk_rx(q[0], 3'h0);
    chk_rx(q[1], 3'h0);
    chk_rx(q[3], 3'h2);
    rd_reg(`ADDR_CSA, v);
    chk(v & 8'h80, 8'h00);
    // Frame error, parity error, clean parity frame
    for (int i = 0; i < 3; i++) begin
      wr_reg(`ADDR_CSC, i > 0 ? 8'h26 : 8'h06);
      v = $urandom;
      rx_send(v, i > 0, i == 1, i == 0);
      chk_rx(v, i == 0 ? 3'h4 : (i == 1 ? 3'h1 : 3'h0));
    end
    // Duplex random bytes, double speed in the second half
    wr_reg(`ADDR_CSC, 8'h06);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr_reg(`ADDR_CSA, 8'h02);
        bit_cycles <= 5'h08;
      end
      v = $urandom;
      remote_uart_i.got_q.delete();
      wr_reg(`ADDR_DATA, v);
      wait_tx(1);
      chk(remote_uart_i.got_q[0], v);
      rx_send(~v, 1'b0, 1'b0, 1'b0);
      chk_rx(~v, 3'h0);
    end
    // Request lines follow enables and buffer state
    wr_reg(`ADDR_CSB, 8'hf8);
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, rx_irq, tc_irq, de_irq}, 8'h03);
    rx_send(8'h5a, 1'b0, 1'b0, 1'b0);
    #1;
    chk({5'h00, rx_irq, tc_irq, de_irq}, 8'h07);
    wr_reg(`ADDR_CSB, 8'h18);
    repeat (2) @(posedge clk);
    #1;
    chk({5'h00, rx_irq, tc_irq, de_irq}, 8'h00);
    chk_rx(8'h5a, 3'h0);
    // Completion flag clears on a written one, double speed kept
    wr_reg(`ADDR_CSA, 8'h42);
    rd_reg(`ADDR_CSA, v);
    chk(v & 8'h62, 8'h22);
    // Sync master, divisor 2, double speed left set
    wr_reg(`ADDR_BAUD_HI, 8'h00);
    wr_reg(`ADDR_BAUD_LO, 8'h02);
    dir <= 1'b1;
    wr_reg(`ADDR_CSC, 8'h46);
    repeat (10) @(posedge clk);
    #1;
    n = 0;
    for (int i = 0; i < 30; i++) begin
      last = pin_out;
      @(posedge clk);
      #1;
      if (pin_out !== last) n++;
    end
    chk(8'(n), 8'h0a);
    chk({7'h00, pin_oe}, 8'h01);
    @(posedge clk);
    dir <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({6'h00, pin_oe, pin_out}, 8'h00);
    // Sync slave: pin clock at a sixteenth of clk, data read on its falls
    q[0] = $urandom;
    wr_reg(`ADDR_DATA, q[0]);
    for (int i = 0; i < 18; i++) begin
      repeat (8) @(posedge clk);
      lclk_in <= ~lclk_in;
      if (lclk_in && i > 2) v = {txd, v[7:1]};
    end
    chk(v, q[0]);
    // Legacy mode hides sync controls and the high divisor
    wr_reg(`ADDR_CSC, 8'h06);
    @(posedge clk);
    compat_mode <= 1'b1;
    dir <= 1'b1;
    wr_reg(`ADDR_CSC, 8'h46);
    rd_reg(`ADDR_CSC, v);
    chk(v, 8'h00);
    rd_reg(`ADDR_BAUD_HI, v);
    chk(v, 8'h00);
    chk({7'h00, pin_oe}, 8'h00);
    give_verdict;
  end
endmodule // test_usart_clock_gen_rx_buffer
`default_nettype wire
